/* File: verilog/tps_scanner.sv */
// Purpose: Poll master toward equipment, display mapper and host-side answerer.
// Assumes: Characters go out through per-channel transmitters on mclk;
//          discrete inputs are raw pins; configuration is quasi-static.
// Notes:   One poll is outstanding across the whole unit at any time.
`timescale 1ns/10ps
`include "tps_regs.svh"
module tps_scanner #(
	parameter logic [22:0] TMO_CYC = 23'(`TPS_TMO_CYC),
	parameter logic [19:0] LEAD_CYC = 20'(`TPS_LEAD_CYC),
	parameter logic [15:0] DIV_LO = 16'(`TPS_DIV_LO),
	parameter logic [15:0] DIV_HI = 16'(`TPS_DIV_HI)
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// Channel configuration
	input wire tps_pkg::tps_mode_t chan_mode_cfg [`TPS_NCHAN],
	input wire logic [9:0] chan_rate_hi,
	input wire logic [9:0] chan_fitted,
	output tps_pkg::tps_mode_t chan_mode [`TPS_NCHAN],
	output logic [9:0] baud_tick,
	input wire logic [9:0] tx_busy,
	output logic [4:0] rts,
	output logic rts_diff,
	// Display configuration
	input wire logic [7:0] disp_used,
	input wire logic [7:0] disp_serial,
	input wire logic [3:0] disp_chan [`TPS_NDISP],
	input wire logic [2:0] disp_in [`TPS_NDISP],
	input wire logic [7:0] disp_scan_list [`TPS_NDISP],
	input wire tps_pkg::tps_disp_bits_t pt_alarm,
	input wire tps_pkg::tps_disp_bits_t pt_bipolar,
	input wire tps_pkg::tps_disp_bits_t pt_invert,
	input wire logic [63:0] disc_in,
	// Poll toward equipment
	output logic poll_valid,
	input wire logic poll_ready,
	output logic [3:0] poll_chan,
	output logic [2:0] poll_disp,
	output logic [2:0] poll_char,
	input wire logic resp_valid,
	input wire logic [3:0] resp_chan,
	input wire logic [2:0] resp_disp,
	input wire logic [2:0] resp_char,
	input wire logic [7:0] resp_data,
	// Host side
	input wire logic host_req_valid,
	input wire logic [2:0] host_req_disp,
	input wire logic [2:0] host_req_char,
	output logic host_rsp_valid,
	output logic [7:0] host_rsp_data,
	output logic [7:0] host_rsp_cos,
	input wire logic host_cmd_valid,
	input wire logic [2:0] host_cmd_disp,
	input wire logic [5:0] host_cmd_point,
	input wire tps_pkg::tps_ctl_t host_cmd_type,
	output logic cmd_valid,
	output logic cmd_disc,
	output logic [3:0] cmd_chan,
	output logic [2:0] cmd_disp,
	output logic [5:0] cmd_point,
	output tps_pkg::tps_ctl_t cmd_type,
	output logic [7:0] disp_failed
);
	import tps_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Alarm points flag rising edges; bipolar ones flag any edge
	function automatic logic [63:0] cos_of(
		input logic [63:0] old_v,
		input logic [63:0] new_v,
		input logic [63:0] alarm,
		input logic [63:0] bipolar
	);
		cos_of = alarm & ((~old_v & new_v) | (bipolar & (old_v ^ new_v)));
	endfunction : cos_of

	function automatic logic [63:0] char_mask(input logic [7:0] list);
		logic [63:0] m;
		m = 64'h0000000000000000;
		for (int i = 0; i < `TPS_NCHAR; i++) begin
			m[i * 8 +: 8] = {8{list[i]}};
		end
		char_mask = m;
	endfunction : char_mask

	function automatic logic chan_ok(input logic [3:0] num, input logic [9:0] fitted);
		chan_ok = (num >= 4'(`TPS_SER_FIRST)) && (num <= 4'(`TPS_SER_LAST))
			&& fitted[num - 4'h1];
	endfunction : chan_ok

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		tps_poll_st_t st;
		logic [2:0] d;
		logic [2:0] c;
		logic [22:0] tmo;
		logic [3:0] pchan;
		logic [2:0] pdisp;
		logic [15:0] div_lo;
		logic [15:0] div_hi;
		logic [1:0] tick;
		logic [63:0] s1;
		logic [63:0] s2;
		logic [63:0] s3;
		tps_disp_bits_t proc;
		tps_disp_bits_t change_of_state_flag;
		logic [7:0] failed;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic [7:0] rsp_cos;
		logic cv;
		logic cdisc;
		logic [3:0] cchan;
		logic [2:0] cdisp;
		logic [5:0] cpoint;
		tps_ctl_t ctype;
	} tps_scan_state_t;

	tps_scan_state_t r;
	tps_scan_state_t next_r;
	logic [9:0] go;
	logic [9:0] req;
	logic hit;
	logic [63:0] upd;
	logic [63:0] en;

	// ----------------------------------------------------------------
	// Channel modes and RTS
	// ----------------------------------------------------------------
	// CTS and DCD have no port: nothing outside can hold off a frame
	for (genvar i = 0; i < `TPS_NCHAN; i++) begin : g_ch
		tps_rts_if u_if();
		if (i >= `TPS_OPT_FIRST && i <= `TPS_OPT_LAST) begin : g_opt
			assign chan_mode[i] = TPS_RS422;
		end else if (i == `TPS_CRAFT) begin : g_craft
			assign chan_mode[i] = TPS_RS232;
		end else begin : g_cfg
			assign chan_mode[i] = chan_mode_cfg[i];
		end
		assign u_if.mode = chan_mode[i];
		assign u_if.tx_req = req[i];
		assign u_if.tx_busy = tx_busy[i];
		assign go[i] = u_if.tx_go;
		tps_rts #(
			.HAS_LEAD(i >= `TPS_LEAD_FIRST && i <= `TPS_LEAD_LAST),
			.LEAD_CYC(LEAD_CYC)
		) u_rts (
			.mclk(mclk),
			.srst(srst),
			.ce(ce),
			.lnk(u_if.seq)
		);
		if (i < 5) begin : g_rts
			assign rts[i] = u_if.rts;
		end
		if (i == 0) begin : g_diff
			assign rts_diff = u_if.rts;
		end
	end

	// Absent option channels never get a frame to send
	always_comb begin
		req = 10'h000;
		if (r.st == TPS_REQ && r.pchan != 4'h0) begin
			req[r.pchan - 4'h1] = 1'b1;
		end
	end

	// Craft port ignores its rate setting
	always_comb begin
		for (int i = 0; i < `TPS_NCHAN; i++) begin
			if (i == `TPS_CRAFT) begin
				baud_tick[i] = `TPS_CRAFT_RATE_HI ? r.tick[1] : r.tick[0];
			end else begin
				baud_tick[i] = chan_rate_hi[i] ? r.tick[1] : r.tick[0];
			end
		end
	end

	assign poll_valid = (r.st == TPS_REQ) && (r.pchan != 4'h0) && go[r.pchan - 4'h1];
	assign poll_chan = r.pchan;
	assign poll_disp = r.pdisp;
	assign poll_char = r.c;
	assign hit = resp_valid && resp_chan == r.pchan && resp_disp == r.pdisp
		&& resp_char == r.c;
	assign host_rsp_valid = r.rsp_valid;
	assign host_rsp_data = r.rsp_data;
	assign host_rsp_cos = r.rsp_cos;
	assign cmd_valid = r.cv;
	assign cmd_disc = r.cdisc;
	assign cmd_chan = r.cchan;
	assign cmd_disp = r.cdisp;
	assign cmd_point = r.cpoint;
	assign cmd_type = r.ctype;
	assign disp_failed = r.failed;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		upd = 64'h0000000000000000;
		en = 64'h0000000000000000;
		next_r.rsp_valid = 1'b0;
		next_r.cv = 1'b0;
		next_r.tick = 2'b00;

		// Shared bit-rate dividers
		if (r.div_lo == DIV_LO - 16'h0001) begin
			next_r.div_lo = 16'h0000;
			next_r.tick[0] = 1'b1;
		end else begin
			next_r.div_lo = r.div_lo + 16'h0001;
		end
		if (r.div_hi == DIV_HI - 16'h0001) begin
			next_r.div_hi = 16'h0000;
			next_r.tick[1] = 1'b1;
		end else begin
			next_r.div_hi = r.div_hi + 16'h0001;
		end

		// Three-stage pin synchroniser for the discrete block
		next_r.s1 = disc_in;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;

		// Host read clears the flags it reports; any set below still wins
		if (host_req_valid) begin
			next_r.rsp_valid = 1'b1;
			if (disp_used[host_req_disp] && disp_scan_list[host_req_disp][host_req_char]) begin
				next_r.rsp_data = r.proc[host_req_disp][{host_req_char, 3'h0} +: 8];
				next_r.rsp_cos = r.change_of_state_flag[host_req_disp][{host_req_char, 3'h0} +: 8];
			end else begin
				next_r.rsp_data = 8'h00;
				next_r.rsp_cos = 8'h00;
			end
			next_r.change_of_state_flag[host_req_disp][{host_req_char, 3'h0} +: 8] = 8'h00;
		end

		// Commands follow the same mapping as the scan data
		if (host_cmd_valid && disp_used[host_cmd_disp]) begin
			next_r.cv = 1'b1;
			next_r.cdisc = !disp_serial[host_cmd_disp];
			next_r.cchan = disp_serial[host_cmd_disp] ? disp_chan[host_cmd_disp] : 4'h0;
			next_r.cdisp = disp_in[host_cmd_disp];
			next_r.cpoint = host_cmd_point;
			next_r.ctype = host_cmd_type;
		end

		// Discrete-sourced displays take the block once two stages agree
		for (int d = 0; d < `TPS_NDISP; d++) begin
			if (disp_used[d] && !disp_serial[d]) begin
				en = char_mask(disp_scan_list[d]);
				upd = ((r.s3 ^ pt_invert[d]) & en & ~(r.s2 ^ r.s3))
					| (r.proc[d] & en & (r.s2 ^ r.s3));
				next_r.change_of_state_flag[d] = next_r.change_of_state_flag[d] | cos_of(r.proc[d], upd, pt_alarm[d], pt_bipolar[d]);
				next_r.proc[d] = upd;
			end
		end

		// Poll engine
		case (r.st)
			TPS_SEEK: begin
				next_r.tmo = 23'h000000;
				if (disp_used[r.d] && disp_serial[r.d] && disp_scan_list[r.d][r.c]) begin
					if (chan_ok(disp_chan[r.d], chan_fitted)) begin
						next_r.pchan = disp_chan[r.d];
						next_r.pdisp = disp_in[r.d];
						next_r.st = TPS_REQ;
					end else begin
						// No channel to poll counts as failed retrieval
						upd = `TPS_FAIL_PAT;
						next_r.change_of_state_flag[r.d] = next_r.change_of_state_flag[r.d]
							| cos_of(r.proc[r.d], upd, pt_alarm[r.d], pt_bipolar[r.d]);
						next_r.proc[r.d] = upd;
						next_r.failed[r.d] = 1'b1;
						{next_r.d, next_r.c} = {r.d, r.c} + 6'h01;
					end
				end else begin
					{next_r.d, next_r.c} = {r.d, r.c} + 6'h01;
				end
			end
			TPS_REQ: begin
				if (poll_valid && poll_ready) begin
					next_r.st = TPS_WAIT;
				end
			end
			TPS_WAIT: begin
				next_r.tmo = r.tmo + 23'h000001;
				if (hit) begin
					en = char_mask(disp_scan_list[r.d]);
					upd = r.proc[r.d];
					upd[{r.c, 3'h0} +: 8] = resp_data ^ pt_invert[r.d][{r.c, 3'h0} +: 8];
					if (r.failed[r.d]) begin
						upd = upd & char_mask(8'h01 << r.c);
					end
					upd = upd & en;
					next_r.change_of_state_flag[r.d] = next_r.change_of_state_flag[r.d]
						| cos_of(r.proc[r.d], upd, pt_alarm[r.d], pt_bipolar[r.d]);
					next_r.proc[r.d] = upd;
					next_r.failed[r.d] = 1'b0;
					{next_r.d, next_r.c} = {r.d, r.c} + 6'h01;
					next_r.st = TPS_SEEK;
				end else if (r.tmo == TMO_CYC - 23'h000001) begin
					upd = `TPS_FAIL_PAT;
					next_r.change_of_state_flag[r.d] = next_r.change_of_state_flag[r.d]
						| cos_of(r.proc[r.d], upd, pt_alarm[r.d], pt_bipolar[r.d]);
					next_r.proc[r.d] = upd;
					next_r.failed[r.d] = 1'b1;
					{next_r.d, next_r.c} = {r.d, r.c} + 6'h01;
					next_r.st = TPS_SEEK;
				end
			end
			default: next_r.st = TPS_SEEK;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end
endmodule : tps_scanner

/* File: common/tps_regs.svh */
// Purpose: Constants for the telemetry poll scanner.
// Assumes: 40 MHz mclk; channel arrays and displays counted from zero inside the logic; poll_chan and disp_chan carry channel numbers from one.
// Notes:   Long counts are top-level parameters whose defaults come from here.
//
// Summary of operation
// - Ten serial channels; channels six to nine may be absent.
// - Channels 1-5 select RS-232/422/485; 6-9 are RS-422; 10 is RS-232.
// - Channels 2-5 in RS-232 raise RTS 10-20 ms early, drop after sending.
// - In RS-422 mode RTS is active from power-up and never released.
// - Channel one also presents RTS on its differential interface.
// - CTS and DCD are ignored on every channel.
// - Each configurable channel runs at 1200 or 2400 bit/s.
// - Channel ten has fixed parameters that configuration cannot change.
// - Poll master toward equipment; slave answering only host polls and commands.
// - A poll waits at most 200 ms for the slave's response.
// - A display has 64 scan points with 64 matching control points.
// - At most eight displays per port, numbered one to eight.
// - Scan data moves as eight-point characters, eight per display.
// - Only scan-list enabled characters are polled, processed or reported.
// - Scan requests carry display and character; reply is exactly that character.
// - Command requests carry display, control point and latch/unlatch/pulse type.
// - Eight 64-point output displays reported, commands accepted for them.
// - Output display source is a channel 2-9 input display or discrete block.
// - Scan and control halves of a display always share one mapping.
// - Failed retrieval forces points 1-63 to zero and point 64 to one.
// - Bipolar alarm points flag change of state on both edges.
`ifndef TPS_REGS_SVH
`define TPS_REGS_SVH
`define TPS_NCHAN 10
`define TPS_NDISP 8
`define TPS_NCHAR 8
`define TPS_CLK_HZ 40000000
`define TPS_TMO_MS 200
`define TPS_TMO_CYC (`TPS_CLK_HZ / 1000 * `TPS_TMO_MS)
`define TPS_LEAD_MS 15
`define TPS_LEAD_CYC ((`TPS_CLK_HZ / 1000 * `TPS_LEAD_MS) + 0)
`define TPS_RATE_LO 1200
`define TPS_RATE_HI 2400
`define TPS_DIV_LO (`TPS_CLK_HZ / `TPS_RATE_LO)
`define TPS_DIV_HI (`TPS_CLK_HZ / `TPS_RATE_HI)
`define TPS_LEAD_FIRST 1
`define TPS_LEAD_LAST 4
`define TPS_SER_FIRST 2
`define TPS_SER_LAST 9
`define TPS_OPT_FIRST 5
`define TPS_OPT_LAST 8
`define TPS_CRAFT 9
`define TPS_CRAFT_RATE_HI 1'b1
`define TPS_FAIL_PAT 64'h8000000000000000
`endif

/* File: common/tps_pkg.sv */
// Purpose: Types shared by the scanner and its RTS sequencer.
// Assumes: Constants live in tps_regs.svh.
// Notes:   Binary codes are written out.
package tps_pkg;
	typedef enum logic [1:0] {
		TPS_RS232 = 2'h0,
		TPS_RS422 = 2'h1,
		TPS_RS485 = 2'h2
	} tps_mode_t;
	typedef enum logic [1:0] {
		TPS_LATCH = 2'h0,
		TPS_UNLATCH = 2'h1,
		TPS_PULSE = 2'h2
	} tps_ctl_t;
	typedef enum logic [1:0] {
		TPS_SEEK = 2'h0,
		TPS_REQ = 2'h1,
		TPS_WAIT = 2'h2
	} tps_poll_st_t;
	typedef enum logic [1:0] {
		TPS_RTS_OFF = 2'h0,
		TPS_RTS_LEAD = 2'h1,
		TPS_RTS_ON = 2'h2
	} tps_rts_st_t;
	typedef logic [7:0][63:0] tps_disp_bits_t;
endpackage : tps_pkg

/* File: common/tps_rts_if.sv */
// Purpose: Per-channel link between poll engine and RTS sequencer.
// Assumes: One instance per serial channel.
// Notes:   tx_busy comes from the channel transmitter on mclk.
`timescale 1ns/10ps
interface tps_rts_if;
	import tps_pkg::*;
	tps_mode_t mode;
	logic tx_req;
	logic tx_busy;
	logic tx_go;
	logic rts;
	modport ctl (output mode, output tx_req, output tx_busy, input tx_go, input rts);
	modport seq (input mode, input tx_req, input tx_busy, output tx_go, output rts);
endinterface : tps_rts_if

/* File: verilog/tps_rts.sv */
// Purpose: RTS sequencing for one serial channel.
// Assumes: tx_req holds until the character is taken; tx_busy covers the whole frame.
// Notes:   Lead time applies only where HAS_LEAD is set and the mode is RS-232.
`timescale 1ns/10ps
module tps_rts #(
	parameter bit HAS_LEAD = 1'b0,
	parameter logic [19:0] LEAD_CYC = 20'h927C0
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	tps_rts_if.seq lnk
);
	import tps_pkg::*;

	typedef struct packed {
		tps_rts_st_t st;
		logic [19:0] cnt;
	} tps_rts_state_t;

	tps_rts_state_t r;
	tps_rts_state_t next_r;
	logic use_lead;

	assign use_lead = HAS_LEAD && (lnk.mode == TPS_RS232);

	always_comb begin
		next_r = r;
		case (r.st)
			TPS_RTS_OFF: begin
				next_r.cnt = 20'h00000;
				if (lnk.tx_req) begin
					next_r.st = use_lead ? TPS_RTS_LEAD : TPS_RTS_ON;
				end
			end
			TPS_RTS_LEAD: begin
				next_r.cnt = r.cnt + 20'h00001;
				if (r.cnt == LEAD_CYC - 20'h00001) begin
					next_r.st = TPS_RTS_ON;
				end
			end
			TPS_RTS_ON: begin
				// Hold until the last bit has left the transmitter
				if (!lnk.tx_req && !lnk.tx_busy) begin
					next_r.st = TPS_RTS_OFF;
				end
			end
			default: next_r.st = TPS_RTS_OFF;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			r <= '{st: TPS_RTS_OFF, cnt: 20'h00000};
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign lnk.tx_go = (r.st == TPS_RTS_ON);
	// RS-422 mode keeps RTS up even through reset
	assign lnk.rts = (lnk.mode == TPS_RS422) || (r.st != TPS_RTS_OFF);
endmodule : tps_rts

/* File: verif/tps_scanner_asserts.sv */
// Purpose: Port-level assertions for the telemetry poll scanner.
// Assumes: One mclk domain with synchronous active-high srst.
// Notes:   Bound into every tps_scanner instance after the module.
`timescale 1ns/10ps
module tps_scanner_asserts (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire tps_pkg::tps_mode_t chan_mode [10],
	input wire logic [9:0] tx_busy,
	input wire logic [4:0] rts,
	input wire logic rts_diff,
	input wire logic [7:0] disp_used,
	input wire logic poll_valid,
	input wire logic poll_ready,
	input wire logic [3:0] poll_chan,
	input wire logic [2:0] poll_disp,
	input wire logic [2:0] poll_char,
	input wire logic host_req_valid,
	input wire logic host_rsp_valid,
	input wire logic host_cmd_valid,
	input wire logic [2:0] host_cmd_disp,
	input wire logic [5:0] host_cmd_point,
	input wire tps_pkg::tps_ctl_t host_cmd_type,
	input wire logic cmd_valid,
	input wire logic [5:0] cmd_point,
	input wire tps_pkg::tps_ctl_t cmd_type,
	input wire logic [7:0] disp_failed
);
	import tps_pkg::*;
	logic [4:0] m422;
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			m422[k] = chan_mode[k] == TPS_RS422;
		end
	end
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	chk_rts_mirror: assert property (rts_diff == rts[0]) else $error("rts mirror");
	chk_rs422_rts: assert property ((m422 & ~rts) == 5'h00) else $error("rs422 rts low");
	chk_fixed_modes: assert property (chan_mode[5] == TPS_RS422 &&
		chan_mode[8] == TPS_RS422 && chan_mode[9] == TPS_RS232) else $error("fixed mode");
	chk_host_answer: assert property (host_req_valid && ce |=> host_rsp_valid)
		else $error("host request unanswered");
	chk_no_unasked: assert property (host_rsp_valid |-> $past(host_req_valid))
		else $error("answer without request");
	chk_cmd_echo: assert property (host_cmd_valid && ce && disp_used[host_cmd_disp] |=>
		cmd_valid && cmd_point == $past(host_cmd_point) && cmd_type == $past(host_cmd_type))
		else $error("command fields");
	chk_cmd_refuse: assert property (host_cmd_valid && !disp_used[host_cmd_disp] |=> !cmd_valid)
		else $error("command on unused display");
	chk_poll_hold: assert property (poll_valid && !poll_ready |=> poll_valid &&
		$stable(poll_chan) && $stable(poll_disp) && $stable(poll_char)) else $error("poll hold");
	chk_one_out: assert property (poll_valid && poll_ready |=> !poll_valid [*2])
		else $error("second poll outstanding");
	chk_poll_range: assert property (poll_valid |-> poll_chan inside {[4'h2:4'h9]})
		else $error("poll channel");
	chk_rts_lead: assert property (poll_valid && poll_chan == 4'h2 &&
		chan_mode[1] == TPS_RS232 |-> $past(rts[1], 19)) else $error("rts lead short");
	chk_rts_drop: assert property ($fell(rts[1]) |-> !$past(tx_busy[1]))
		else $error("rts dropped while sending");
	cov_poll: cover property (poll_valid && poll_ready);
	cov_cmd: cover property (cmd_valid);
	cov_fail: cover property ($rose(disp_failed[0]));
endmodule : tps_scanner_asserts

bind tps_scanner tps_scanner_asserts u_tps_scanner_asserts (.mclk, .srst, .ce, .chan_mode,
	.tx_busy, .rts, .rts_diff, .disp_used, .poll_valid, .poll_ready, .poll_chan, .poll_disp,
	.poll_char, .host_req_valid, .host_rsp_valid, .host_cmd_valid, .host_cmd_disp,
	.host_cmd_point, .host_cmd_type, .cmd_valid, .cmd_point, .cmd_type, .disp_failed);

/* File: verif/tps_equip_model.sv */
// Purpose: Monitored equipment slave together with its channel transmitter.
// Assumes: Answers only the poll it accepted, one at a time.
// Notes:   mute withholds answers; slow stretches reply time inside the window.
`timescale 1ns/10ps
module tps_equip_model (
	input wire logic mclk,
	input wire logic srst,
	input wire logic mute,
	input wire logic slow,
	input wire logic [7:0] pat,
	input wire logic poll_valid,
	output logic poll_ready,
	input wire logic [3:0] poll_chan,
	input wire logic [2:0] poll_disp,
	input wire logic [2:0] poll_char,
	output logic [9:0] tx_busy,
	output logic resp_valid,
	output logic [3:0] resp_chan,
	output logic [2:0] resp_disp,
	output logic [2:0] resp_char,
	output logic [7:0] resp_data
);
	int cnt;
	logic [9:0] req;
	// -------------
	// Slave answers
	// -------------
	always @(posedge mclk) begin
		resp_valid <= 1'b0;
		// Idle lines toggle so a stale answer can never be mistaken for a fresh one
		{resp_chan, resp_disp, resp_char, resp_data} <= ~{resp_chan, resp_disp, resp_char, resp_data};
		poll_ready <= poll_valid && !poll_ready && cnt == 0;
		if (srst) begin
			poll_ready <= 1'b0;
			cnt <= 0;
			tx_busy <= 10'h000;
			{resp_chan, resp_disp, resp_char, resp_data} <= 18'h00000;
		end else if (poll_valid && poll_ready) begin
			req <= {poll_chan, poll_disp, poll_char};
			cnt <= slow ? 60 : 4;
			tx_busy[poll_chan - 4'h1] <= 1'b1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 2)
				tx_busy <= 10'h000;
			if (cnt == 1 && !mute) begin
				resp_valid <= 1'b1;
				{resp_chan, resp_disp, resp_char} <= req;
				resp_data <= pat;
			end
		end
	end
endmodule : tps_equip_model

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the telemetry poll scanner.
// Assumes: Shortened timeout, lead and divider parameters.
// Notes:   Inputs change at the falling edge; ce stays high throughout.
`timescale 1ns/10ps
module testbench;
	import tps_pkg::*;
	typedef struct {logic [2:0] d; logic [2:0] c; logic [7:0] v;} tps_row_t;
	logic mclk, srst, ce, mute, slow, poll_valid, poll_ready, resp_valid, rts_diff;
	logic host_req_valid, host_rsp_valid, host_cmd_valid, cmd_valid, cmd_disc;
	logic [7:0] pat, disp_used, disp_serial, resp_data, host_rsp_data, host_rsp_cos, disp_failed;
	logic [9:0] chan_rate_hi, chan_fitted, baud_tick, tx_busy;
	logic [4:0] rts;
	logic [3:0] poll_chan, resp_chan, cmd_chan, disp_chan [8];
	logic [2:0] poll_disp, poll_char, resp_disp, resp_char, host_req_disp, host_req_char;
	logic [2:0] host_cmd_disp, cmd_disp, disp_in [8];
	logic [5:0] host_cmd_point, cmd_point;
	logic [7:0] disp_scan_list [8];
	logic [63:0] disc_in;
	tps_mode_t chan_mode_cfg [10];
	tps_mode_t chan_mode [10];
	tps_ctl_t host_cmd_type, cmd_type;
	tps_disp_bits_t pt_alarm, pt_bipolar, pt_invert;
	int failures, num_checks, n;
	int bk [3] = '{0, 1, 9};
	int bx [3] = '{8, 4, 4};
	// Change flags equal the data: every point is an alarm rising from zero
	tps_row_t rows [7] = '{'{3'h0, 3'h0, 8'h5A}, '{3'h0, 3'h1, 8'h5A}, '{3'h0, 3'h2, 8'h00},
		'{3'h1, 3'h0, 8'hA5}, '{3'h2, 3'h1, 8'hCD}, '{3'h5, 3'h0, 8'h00}, '{3'h3, 3'h0, 8'h00}};

	tps_scanner #(.TMO_CYC(23'hC8), .LEAD_CYC(20'h14), .DIV_LO(16'h8), .DIV_HI(16'h4))
	u_tps_scanner (.mclk, .srst, .ce, .chan_mode_cfg, .chan_rate_hi, .chan_fitted, .chan_mode,
		.baud_tick, .tx_busy, .rts, .rts_diff, .disp_used, .disp_serial, .disp_chan, .disp_in,
		.disp_scan_list, .pt_alarm, .pt_bipolar, .pt_invert, .disc_in, .poll_valid, .poll_ready,
		.poll_chan, .poll_disp, .poll_char, .resp_valid, .resp_chan, .resp_disp, .resp_char,
		.resp_data, .host_req_valid, .host_req_disp, .host_req_char, .host_rsp_valid,
		.host_rsp_data, .host_rsp_cos, .host_cmd_valid, .host_cmd_disp, .host_cmd_point,
		.host_cmd_type, .cmd_valid, .cmd_disc, .cmd_chan, .cmd_disp, .cmd_point, .cmd_type,
		.disp_failed);
	tps_equip_model u_tps_equip_model (.mclk, .srst, .mute, .slow, .pat, .poll_valid,
		.poll_ready, .poll_chan, .poll_disp, .poll_char, .tx_busy, .resp_valid, .resp_chan,
		.resp_disp, .resp_char, .resp_data);

	// ---------------
	// Tasks and clock
	// ---------------
	task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_cnt(input int got, input int exp, input string what);
		num_checks++;
		if (got != exp) begin
			failures++;
			$display("BAD at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask : cmp_cnt
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic host_rd(input logic [2:0] d, input logic [2:0] c);
		@(negedge mclk);
		host_req_valid = 1'b1;
		host_req_disp = d;
		host_req_char = c;
		@(negedge mclk);
		host_req_valid = 1'b0;
		cmp_val(64'(host_rsp_valid), 64'h1, "answer");
	endtask : host_rd
	task automatic host_cmd(input logic [2:0] d, input logic [5:0] p, input tps_ctl_t t);
		@(negedge mclk);
		host_cmd_valid = 1'b1;
		host_cmd_disp = d;
		host_cmd_point = p;
		host_cmd_type = t;
		@(negedge mclk);
		host_cmd_valid = 1'b0;
	endtask : host_cmd
	task automatic tick_gap(input int k);
		n = 0;
		while (baud_tick[k] !== 1'b1 && n < 99) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (baud_tick[k] !== 1'b1 && n < 99);
	endtask : tick_gap
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (8000) @(posedge mclk);
		failures++;
		complete_run();
	end
	initial begin
		{srst, ce, mute, slow, host_req_valid, host_cmd_valid} = 6'h30;
		{host_req_disp, host_req_char, host_cmd_disp, host_cmd_point} = 18'h00000;
		host_cmd_type = TPS_LATCH;
		failures = 0;
		num_checks = 0;
		pat = 8'h5A;
		// Optional and craft channels are set against their fixed modes on purpose
		chan_mode_cfg = '{TPS_RS232, TPS_RS232, TPS_RS422, TPS_RS485, TPS_RS232,
			TPS_RS232, TPS_RS232, TPS_RS232, TPS_RS232, TPS_RS422};
		chan_rate_hi = 10'h002;
		chan_fitted = 10'h3BF;
		disp_used = 8'h0F;
		disp_serial = 8'h0B;
		disp_chan = '{0: 4'h2, 1: 4'h4, 3: 4'h7, default: 4'h0};
		disp_in = '{0: 3'h5, default: 3'h0};
		disp_scan_list = '{0: 8'h03, 1: 8'h81, 2: 8'hFF, 3: 8'h03, default: 8'h00};
		pt_alarm = '1;
		pt_bipolar = '0;
		pt_bipolar[0] = '1;
		pt_invert = '0;
		pt_invert[1][7:0] = 8'hFF;
		disc_in = 64'h0123456789ABCDEF;
		repeat (6) @(negedge mclk);
		cmp_val(64'(rts), 64'h4, "reset rts");
		cmp_val(64'({poll_valid, disp_failed}), 64'h0, "reset state");
		srst = 1'b0;
		foreach (bk[i]) begin
			tick_gap(bk[i]);
			cmp_cnt(n, bx[i], "bit time");
		end
		repeat (500) @(negedge mclk);
		cmp_val(64'(disp_failed), 64'h8, "absent channel");
		foreach (rows[i]) begin
			host_rd(rows[i].d, rows[i].c);
			cmp_val(64'(host_rsp_data), 64'(rows[i].v), "data");
			cmp_val(64'(host_rsp_cos), 64'(rows[i].v), "cos");
		end
		host_rd(3'h0, 3'h0);
		cmp_val(64'({host_rsp_data, host_rsp_cos}), 64'h5A00, "cos cleared");
		pat = 8'h0F;
		slow = 1'b1;
		repeat (800) @(negedge mclk);
		host_rd(3'h0, 3'h0);
		cmp_val(64'({host_rsp_data, host_rsp_cos}), 64'h0F55, "bipolar");
		host_rd(3'h1, 3'h0);
		cmp_val(64'({host_rsp_data, host_rsp_cos}), 64'hF050, "alarm rise");
		for (int t = 0; t < 3; t++) begin
			host_cmd(3'h0, 6'(t + 40), tps_ctl_t'(t));
			cmp_val(64'({cmd_valid, cmd_disc, cmd_chan, cmd_disp, cmd_point, cmd_type}),
				64'({1'b1, 1'b0, 4'h2, 3'h5, 6'(t + 40), 2'(t)}), "command");
		end
		host_cmd(3'h2, 6'h3F, TPS_PULSE);
		cmp_val(64'({cmd_valid, cmd_disc, cmd_chan}), 64'h30, "discrete command");
		host_cmd(3'h5, 6'h01, TPS_LATCH);
		cmp_val(64'(cmd_valid), 64'h0, "unused display");
		mute = 1'b1;
		slow = 1'b0;
		repeat (1500) @(negedge mclk);
		cmp_val(64'(disp_failed), 64'h0B, "poll failure");
		host_rd(3'h1, 3'h7);
		cmp_val(64'(host_rsp_data), 64'h80, "point 64");
		complete_run();
	end
endmodule : testbench
